/* cip_pkg.sv */
// Constants for the change-notify and I2C priority register block
package cip_pkg;
    // ======================================================
    // Register map
    localparam int         ADDR_W        = 4;
    localparam logic [3:0] PRIO_REG_ADDR = 4'h0;
    localparam logic [3:0] READBACK_ADDR = 4'h4;
    localparam int         DATA_W        = 32;
    localparam int         REG_W         = 16;
    localparam int         FIELD_W       = 3;
    // ======================================================
    // Field positions
    localparam int         CN_LSB        = 12;
    localparam int         MEV_LSB       = 4;
    localparam int         SEV_LSB       = 0;
    // ======================================================
    // Values
    localparam logic [2:0]  FIELD_RESET   = 3'h4;
    localparam logic [2:0]  FIELD_OFF     = 3'h0;
    localparam logic [15:0] IMPL_MASK     = 16'h7077;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam int          NUM_SRC       = 3;
endpackage

/* cip_prio_reg.sv */
// Priority register for change-notify and I2C interrupts
//
// Contract
// - Change-notify priority field at bits 14-12
// - I2C master 6-4, slave 2-0 fields
// - 111 highest, 001 lowest, 000 disables
// - Each field resets to 100
`timescale 1ns/1ps
module cip_prio_reg (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [3:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    output logic      [2:0]  CN_PRIO_OUT,
    output logic      [2:0]  MEV_PRIO_OUT,
    output logic      [2:0]  SEV_PRIO_OUT,
    output logic      [2:0]  SRC_ENABLED_OUT
);
    // ======================================================
    // Bus handshake: one wait cycle per access
    logic        ack_reg;
    logic [2:0]  cn_reg;
    logic [2:0]  mev_reg;
    logic [2:0]  sev_reg;
    logic [15:0] reg_view;
    logic        req;
    logic        wr_take;
    logic        rd_take;
    logic        cn_we;
    logic        low_we;
    logic [2:0]  cn_wdata;
    logic [2:0]  mev_wdata;
    logic [2:0]  sev_wdata;
    logic [31:0] rdata_next;
    logic [cip_pkg::NUM_SRC-1:0][cip_pkg::FIELD_W-1:0] field_vec;

    assign req = AVS_READ_IN | AVS_WRITE_IN;
    assign AVS_WAITREQUEST_OUT = req & ~ack_reg;
    assign wr_take = AVS_WRITE_IN & ack_reg
                   & (AVS_ADDRESS_IN == cip_pkg::PRIO_REG_ADDR);
    assign rd_take = AVS_READ_IN & ~ack_reg;

    // ======================================================
    // Write strobes per byte lane
    // Lane 1 carries the upper field, lane 0 the lower two
    assign cn_we     = wr_take & AVS_BYTEENABLE_IN[1];
    assign low_we    = wr_take & AVS_BYTEENABLE_IN[0];
    assign cn_wdata  = AVS_WRITEDATA_IN[cip_pkg::CN_LSB +: cip_pkg::FIELD_W];
    assign mev_wdata = AVS_WRITEDATA_IN[cip_pkg::MEV_LSB +: cip_pkg::FIELD_W];
    assign sev_wdata = AVS_WRITEDATA_IN[cip_pkg::SEV_LSB +: cip_pkg::FIELD_W];

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ack_reg <= 1'b0;
        end else if (ack_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // ======================================================
    // Priority fields
    // Change-notify field, written from byte lane 1
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cn_reg <= cip_pkg::FIELD_RESET;
        end else if (cn_we) begin
            cn_reg <= cn_wdata;
        end
    end

    // Master-event field, written from byte lane 0
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mev_reg <= cip_pkg::FIELD_RESET;
        end else if (low_we) begin
            mev_reg <= mev_wdata;
        end
    end

    // Slave-event field, written from byte lane 0
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sev_reg <= cip_pkg::FIELD_RESET;
        end else if (low_we) begin
            sev_reg <= sev_wdata;
        end
    end

    // ======================================================
    // Readback
    // Register image with unimplemented bits forced low
    always_comb begin
        reg_view = '0;
        reg_view[cip_pkg::CN_LSB +: cip_pkg::FIELD_W]  = cn_reg;
        reg_view[cip_pkg::MEV_LSB +: cip_pkg::FIELD_W] = mev_reg;
        reg_view[cip_pkg::SEV_LSB +: cip_pkg::FIELD_W] = sev_reg;
        reg_view = reg_view & cip_pkg::IMPL_MASK;
    end

    // Read data select by address
    always_comb begin
        rdata_next = cip_pkg::UNMAPPED_DATA;
        if (AVS_ADDRESS_IN == cip_pkg::PRIO_REG_ADDR) begin
            rdata_next = {16'h0000, reg_view};
        end else if (AVS_ADDRESS_IN == cip_pkg::READBACK_ADDR) begin
            rdata_next = {29'h0000_0000, SRC_ENABLED_OUT};
        end
    end

    // Read data captured in the wait cycle, held until next read
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            AVS_READDATA_OUT <= cip_pkg::UNMAPPED_DATA;
        end else if (rd_take) begin
            AVS_READDATA_OUT <= rdata_next;
        end
    end

    // ======================================================
    // Arbitration outputs
    assign CN_PRIO_OUT  = cn_reg;
    assign MEV_PRIO_OUT = mev_reg;
    assign SEV_PRIO_OUT = sev_reg;

    // Source order: change-notify, master event, slave event
    assign field_vec = {cn_reg, mev_reg, sev_reg};

    generate
        for (genvar s = 0; s < cip_pkg::NUM_SRC; s++) begin : g_src
            // Code zero masks the source
            assign SRC_ENABLED_OUT[s] =
                (field_vec[s] != cip_pkg::FIELD_OFF);
        end
    endgenerate

    // ======================================================
    // Checks
    cn_write_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        cn_we
        |=> CN_PRIO_OUT == $past(cn_wdata))
        else $error("change-notify field not written");
    mev_write_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        low_we
        |=> MEV_PRIO_OUT == $past(mev_wdata))
        else $error("master field not written");
    sev_write_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        low_we
        |=> SEV_PRIO_OUT == $past(sev_wdata))
        else $error("slave field not written");
    src_off_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        SRC_ENABLED_OUT[2] == (CN_PRIO_OUT != cip_pkg::FIELD_OFF))
        else $error("change-notify disable decode wrong");
    mev_off_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        SRC_ENABLED_OUT[1] == (MEV_PRIO_OUT != cip_pkg::FIELD_OFF))
        else $error("master disable decode wrong");
    sev_off_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        SRC_ENABLED_OUT[0] == (SEV_PRIO_OUT != cip_pkg::FIELD_OFF))
        else $error("slave disable decode wrong");
    unimpl_zero_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        AVS_READ_IN && ack_reg
        && AVS_ADDRESS_IN == cip_pkg::PRIO_REG_ADDR
        |-> (AVS_READDATA_OUT & ~{16'h0000, cip_pkg::IMPL_MASK})
            == cip_pkg::UNMAPPED_DATA)
        else $error("unimplemented bits not zero");
    unmapped_rd_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        AVS_READ_IN && ack_reg
        && AVS_ADDRESS_IN != cip_pkg::PRIO_REG_ADDR
        && AVS_ADDRESS_IN != cip_pkg::READBACK_ADDR
        |-> AVS_READDATA_OUT == cip_pkg::UNMAPPED_DATA)
        else $error("unmapped read not zero");
    enable_rd_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        AVS_READ_IN && ack_reg
        && AVS_ADDRESS_IN == cip_pkg::READBACK_ADDR
        |-> AVS_READDATA_OUT == {29'h0000_0000, SRC_ENABLED_OUT})
        else $error("enable readback wrong");
    reset_val_a: assert property (@(posedge REF_CLK_IN)
        $fell(RST_IN) |-> CN_PRIO_OUT == cip_pkg::FIELD_RESET
        && MEV_PRIO_OUT == cip_pkg::FIELD_RESET
        && SEV_PRIO_OUT == cip_pkg::FIELD_RESET)
        else $error("fields not 100 after reset");
    hold_field_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !wr_take |=> $stable(CN_PRIO_OUT) && $stable(MEV_PRIO_OUT)
        && $stable(SEV_PRIO_OUT))
        else $error("field changed without write");
    rdata_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !rd_take |=> $stable(AVS_READDATA_OUT))
        else $error("read data changed without read");
    wait_one_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        req && !ack_reg |=> !AVS_WAITREQUEST_OUT)
        else $error("waitrequest held too long");
    idle_wait_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !req |-> !AVS_WAITREQUEST_OUT)
        else $error("waitrequest high while idle");

    // ======================================================
    // Coverage
    write_cov: cover property (@(posedge REF_CLK_IN) wr_take);
    read_cov: cover property (@(posedge REF_CLK_IN)
        AVS_READ_IN && ack_reg);
    off_cov: cover property (@(posedge REF_CLK_IN)
        SRC_ENABLED_OUT == 3'h0);
    lane_cov: cover property (@(posedge REF_CLK_IN)
        low_we && !cn_we);
    enable_rd_cov: cover property (@(posedge REF_CLK_IN)
        rd_take && AVS_ADDRESS_IN == cip_pkg::READBACK_ADDR);
endmodule

/* tb_cip_prio_reg.sv */
// Self-checking bench for the priority register block
`timescale 1ns/1ps
module tb_cip_prio_reg;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic [3:0]  addr       = 4'h0;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wdata      = 32'h0000_0000;
    logic [3:0]  be         = 4'hF;
    logic [31:0] rdata;
    logic        waitreq;
    logic [2:0]  cn, mev, sev, en, v;
    logic [31:0] q;
    int          failures   = 0;
    int          n_compared = 0;
    always #12.5 clk = ~clk;
    cip_prio_reg dut (.REF_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq), .CN_PRIO_OUT(cn), .MEV_PRIO_OUT(mev),
        .SEV_PRIO_OUT(sev), .SRC_ENABLED_OUT(en));
    // ==========================================
    // Avalon transfer, held until waitrequest low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= !w;
        wr    <= w;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Counts: compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'h0000_4044);
        chk({20'h0, cn, mev, sev, en}, 32'h0000_0927);
        $display("Test reset values done");
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'h0000_7077);
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            bus(1'b1, 4'h0, {16'hFFFF, 1'b1, v, 5'h1F, v, 1'b1, v}, 4'hF);
            bus(1'b0, 4'h0, 32'h0, 4'hF);
            chk(q, {17'h0, v, 5'h0, v, 1'b0, v});
            chk({20'h0, cn, mev, sev, en}, {20'h0, v, v, v, {3{v != 3'h0}}});
        end
        $display("Test field codes done");
        bus(1'b1, 4'h0, 32'h0000_0011, 4'h1);
        bus(1'b1, 4'h8, 32'h0000_0000, 4'hF);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        chk(q, 32'h0000_0000);
        bus(1'b1, 4'h4, 32'h0000_0000, 4'hF);
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        chk(q, 32'h0000_0007);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'h0000_7011);
        $display("Test lanes and unmapped done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'h0000_4044);
        $display("Test second reset done");
        summarize();
    end
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
